// [core/uhb_regs.svh]
// Operation
// - eight-bit data bus driven only during reads, otherwise released
// - data bit 0 is least significant and first serial bit
// - low ready input means modem ready; level mirrored in status register
// - writing one to modem control bit 0 drives terminal ready low
// - terminal ready high after writing zero to bit 0 and after reset
// - interrupt output enabled only while control bit 3 set; sources via enable register
// - interrupt for line errors, rx data, tx space, modem status changes when enabled
// - interrupt output released to high impedance after reset
// - read strobe falling edge drives register chosen by address bits
// - write strobe rising edge stores bus into addressed register of selected channel
// - control bit 3 set: interrupt driven, user output low; clear: released, high
// - user output high after reset
// - active-high reset returns registers and outputs to reset state
// - during reset serial transmit disabled and serial receive ignored
// - ring input rising edge raises modem status interrupt; level in status register
`ifndef UHB_REGS_SVH
`define UHB_REGS_SVH
`define UHB_ADDR_IER 3'h1
`define UHB_ADDR_MCR 3'h4
`define UHB_ADDR_MSR 3'h6
`define UHB_ADDR_SCR 3'h7
`define UHB_MCR_DTR_BIT 0
`define UHB_MCR_OUT_BIT 3
`define UHB_IER_RX_BIT 0
`define UHB_IER_TX_BIT 1
`define UHB_IER_LS_BIT 2
`define UHB_IER_MS_BIT 3
`define UHB_MSR_DDSR_BIT 1
`define UHB_MSR_TERI_BIT 2
`define UHB_MSR_DSR_BIT 5
`define UHB_MSR_RI_BIT 6
`define UHB_RST_BYTE 8'h00
`define UHB_PIN_IDLE 1'h1
`define UHB_FLAG_RST 1'h0
`define UHB_SYNC_RST 17'h11f00
`endif

// [core/uhb_pkg.sv]
package uhb_pkg;
  typedef struct packed {
    logic line_err;
    logic rx_avail;
    logic tx_space;
  } uhb_src_t;
  typedef struct packed {
    logic [7:0] interrupt_enable_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] scr;
  } uhb_regs_t;
endpackage

// [core/uhb_channel.sv]
`timescale 1ns/1ps
`include "uhb_regs.svh"
module uhb_channel
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_CHANNEL_SELECT_N,
  input wire logic [2:0] I_ADDR,
  input wire logic I_READ_STROBE_N,
  input wire logic I_WRITE_STROBE_N,
  input wire logic [7:0] I_DATA,
  output logic [7:0] O_DATA,
  output logic O_DATA_OE,
  input wire logic I_SET_READY_IN_N,
  input wire logic I_RING_IN_N,
  output logic O_TERMINAL_READY_OUT_N,
  output logic O_USER_OUTPUT_N,
  output logic O_CHANNEL_IRQ,
  output logic O_CHANNEL_IRQ_OE,
  input wire uhb_pkg::uhb_src_t I_SRC,
  input wire logic I_SERIAL_RX,
  output logic O_SERIAL_TX,
  output logic O_SERIAL_RX_VALID,
  input wire logic I_SERIAL_TX_IN
);
  // every bus and modem pin is asynchronous to the clock, so each passes two flops first
  // the flops reset to the idle pin levels, so leaving reset shows no false strobe edge
  localparam int SYNC_W = 17;
  localparam logic [16:0] SYNC_RST = `UHB_SYNC_RST;

  wire [16:0] pin_raw;
  wire [16:0] pin_sync;
  logic cs_n;
  logic [2:0] addr;
  logic rd_n;
  logic wr_n;
  logic dsr_n;
  logic ri_n;
  logic rx_s;
  logic [7:0] wdata;

  logic rd_d_r;
  logic wr_d_r;
  logic dsr_d_r;
  logic ri_d_r;
  logic ddsr_r;
  logic teri_r;
  logic rd_active_r;
  logic [7:0] rdata_r;
  uhb_pkg::uhb_regs_t regs_r;

  logic selected;
  logic rd_fall;
  logic wr_rise;
  logic wr_ier;
  logic wr_mcr;
  logic wr_scr;
  logic msr_read;
  logic ri_rise;
  logic dsr_chg;
  logic [7:0] msr_val;
  logic ms_pend;
  logic src_ls;
  logic src_rx;
  logic src_tx;
  logic src_ms;
  logic irq_any;
  logic out_en;

  logic [7:0] ier_nxt;
  logic [7:0] mcr_nxt;
  logic [7:0] scr_nxt;
  logic ddsr_nxt;
  logic teri_nxt;
  logic [7:0] rdata_nxt;
  logic rd_active_nxt;

  // one decoder serves every strobe, so reads and writes agree on the map
  function automatic logic reg_hit(input logic [2:0] a, input logic [2:0] code, input logic strobe);
    reg_hit = strobe & (a == code);
  endfunction

  // unmapped addresses read as zero rather than an echo of the last value
  function automatic logic [7:0] rd_mux(input logic [2:0] a, input uhb_pkg::uhb_regs_t r, input logic [7:0] m);
    unique case (a)
      `UHB_ADDR_IER: rd_mux = r.interrupt_enable_reg;
      `UHB_ADDR_MCR: rd_mux = r.modem_control_reg;
      `UHB_ADDR_MSR: rd_mux = m;
      `UHB_ADDR_SCR: rd_mux = r.scr;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  assign pin_raw = {I_CHANNEL_SELECT_N, I_ADDR, I_READ_STROBE_N, I_WRITE_STROBE_N, I_SET_READY_IN_N, I_RING_IN_N,
    I_SERIAL_RX, I_DATA};

  // one cell per pin keeps each flop pair private to that pin
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1)
    begin : g_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge I_CLK_SYS or posedge I_RESET)
      begin
        if (I_RESET)
        begin
          meta_r <= SYNC_RST[gi];
          sync_r <= SYNC_RST[gi];
        end
        else
        begin
          meta_r <= pin_raw[gi];
          sync_r <= meta_r;
        end
      end
      assign pin_sync[gi] = sync_r;
    end
  endgenerate

  assign cs_n = pin_sync[16];
  assign addr = pin_sync[15:13];
  assign rd_n = pin_sync[12];
  assign wr_n = pin_sync[11];
  assign dsr_n = pin_sync[10];
  assign ri_n = pin_sync[9];
  assign rx_s = pin_sync[8];
  // d0 is the lsb and stays at bit 0, so the bus bits keep their order
  assign wdata = pin_sync[7:0];

  // an access aimed at the other channel leaves this one untouched
  assign selected = ~cs_n;
  assign rd_fall = rd_d_r & ~rd_n & selected;
  assign wr_rise = ~wr_d_r & wr_n & selected;
  assign wr_ier = reg_hit(addr, `UHB_ADDR_IER, wr_rise);
  assign wr_mcr = reg_hit(addr, `UHB_ADDR_MCR, wr_rise);
  assign wr_scr = reg_hit(addr, `UHB_ADDR_SCR, wr_rise);
  assign msr_read = reg_hit(addr, `UHB_ADDR_MSR, rd_fall);
  assign ri_rise = ~ri_d_r & ri_n;
  assign dsr_chg = dsr_d_r ^ dsr_n;

  // status bits hold inverted pin levels: a low pin reads as one (asserted)
  assign msr_val = {1'h0, ~ri_n, ~dsr_n, 2'h0, teri_r, ddsr_r, 1'h0};
  assign ms_pend = ddsr_r | teri_r;
  // interrupt sources are levels from this clock domain and pass no synchroniser
  assign src_ls = regs_r.interrupt_enable_reg[`UHB_IER_LS_BIT] & I_SRC.line_err;
  assign src_rx = regs_r.interrupt_enable_reg[`UHB_IER_RX_BIT] & I_SRC.rx_avail;
  assign src_tx = regs_r.interrupt_enable_reg[`UHB_IER_TX_BIT] & I_SRC.tx_space;
  assign src_ms = regs_r.interrupt_enable_reg[`UHB_IER_MS_BIT] & ms_pend;
  assign irq_any = src_ls | src_rx | src_tx | src_ms;
  assign out_en = regs_r.modem_control_reg[`UHB_MCR_OUT_BIT];

  assign ier_nxt = wr_ier ? wdata : regs_r.interrupt_enable_reg;
  assign mcr_nxt = wr_mcr ? wdata : regs_r.modem_control_reg;
  assign scr_nxt = wr_scr ? wdata : regs_r.scr;
  // a status read clears the delta flags, but a new edge in that same cycle wins
  assign ddsr_nxt = dsr_chg | (ddsr_r & ~msr_read);
  assign teri_nxt = ri_rise | (teri_r & ~msr_read);
  // read data is caught on the strobe edge and held, so the host sees one value per access
  assign rdata_nxt = rd_fall ? rd_mux(addr, regs_r, msr_val) : rdata_r;
  assign rd_active_nxt = rd_fall | (rd_active_r & ~rd_n & selected);

  // the delayed copies reset to the idle levels, so leaving reset fakes no edge
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      rd_d_r <= `UHB_PIN_IDLE;
    end
    else
    begin
      rd_d_r <= rd_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      wr_d_r <= `UHB_PIN_IDLE;
    end
    else
    begin
      wr_d_r <= wr_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      dsr_d_r <= `UHB_PIN_IDLE;
    end
    else
    begin
      dsr_d_r <= dsr_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      ri_d_r <= `UHB_PIN_IDLE;
    end
    else
    begin
      ri_d_r <= ri_n;
    end
  end

  // the data bus passes the same two flops, so the host need hold it only one clock past the rising strobe
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      regs_r.interrupt_enable_reg <= `UHB_RST_BYTE;
    end
    else
    begin
      regs_r.interrupt_enable_reg <= ier_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      regs_r.modem_control_reg <= `UHB_RST_BYTE;
    end
    else
    begin
      regs_r.modem_control_reg <= mcr_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      regs_r.scr <= `UHB_RST_BYTE;
    end
    else
    begin
      regs_r.scr <= scr_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      ddsr_r <= `UHB_FLAG_RST;
    end
    else
    begin
      ddsr_r <= ddsr_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      teri_r <= `UHB_FLAG_RST;
    end
    else
    begin
      teri_r <= teri_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      rdata_r <= `UHB_RST_BYTE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      rd_active_r <= `UHB_FLAG_RST;
    end
    else
    begin
      rd_active_r <= rd_active_nxt;
    end
  end

  assign O_DATA = rdata_r;
  assign O_DATA_OE = rd_active_r;
  assign O_TERMINAL_READY_OUT_N = ~regs_r.modem_control_reg[`UHB_MCR_DTR_BIT];
  // mcr resets to zero, so the irq pin floats and the user pin sits high straight out of reset
  assign O_USER_OUTPUT_N = ~out_en;
  assign O_CHANNEL_IRQ = out_en & irq_any;
  assign O_CHANNEL_IRQ_OE = out_en;
  // reset holds the line idle and masks the receiver; the async reset forces both at once
  assign O_SERIAL_TX = I_RESET | I_SERIAL_TX_IN;
  assign O_SERIAL_RX_VALID = ~I_RESET & rx_s;
endmodule // uhb_channel

// [verification/uhb_props.sv]
`timescale 1ns/1ps
module uhb_props (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_CHANNEL_SELECT_N,
  input wire logic I_READ_STROBE_N,
  input wire logic I_WRITE_STROBE_N,
  input wire logic O_DATA_OE,
  input wire logic O_TERMINAL_READY_OUT_N,
  input wire logic O_USER_OUTPUT_N,
  input wire logic O_CHANNEL_IRQ,
  input wire logic O_CHANNEL_IRQ_OE
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  a_reset_state: assert property ($fell(I_RESET) |-> !O_DATA_OE && O_TERMINAL_READY_OUT_N &&
    O_USER_OUTPUT_N && !O_CHANNEL_IRQ_OE) else $error("outputs not idle");
  a_read_drive: assert property ($fell(I_READ_STROBE_N) && !I_CHANNEL_SELECT_N |-> ##[2:4] O_DATA_OE)
    else $error("read not driven");
  a_read_release: assert property (I_READ_STROBE_N [*4] |-> !O_DATA_OE)
    else $error("bus held");
  a_sel_release: assert property (I_CHANNEL_SELECT_N [*4] |-> !O_DATA_OE)
    else $error("bus held unselected");
  // six quiet cycles cover the two sync flops plus the register stage
  a_ready_hold: assert property (I_WRITE_STROBE_N [*6] |-> $stable(O_TERMINAL_READY_OUT_N))
    else $error("ready moved");
  a_user_hold: assert property (I_WRITE_STROBE_N [*6] |-> $stable(O_USER_OUTPUT_N))
    else $error("user moved");
  a_irq_gate: assert property (O_CHANNEL_IRQ |-> O_CHANNEL_IRQ_OE)
    else $error("irq ungated");
  a_user_pair: assert property (O_USER_OUTPUT_N != O_CHANNEL_IRQ_OE)
    else $error("user and irq enable disagree");
  c_read: cover property ($rose(O_DATA_OE));
  c_ready: cover property ($fell(O_TERMINAL_READY_OUT_N));
  c_irq: cover property ($rose(O_CHANNEL_IRQ));
endmodule // uhb_props
bind uhb_channel uhb_props u_props (.*);

// [verification/uhb_host.sv]
`timescale 1ns/1ps
module uhb_host (
  input wire logic i_clk,
  input wire logic [7:0] i_bus,
  output logic o_sel_n = 1'b1,
  output logic o_rd_n = 1'b1,
  output logic o_wr_n = 1'b1,
  output logic [2:0] o_addr = 3'h0,
  output logic [7:0] o_data = 8'h00
);
  // strobes stay 5 cycles each way; the pins are synchronised, so 3 is the floor
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] di, output logic [7:0] dq);
    @(negedge i_clk);
    o_sel_n = 1'b0;
    o_addr = a;
    o_data = w ? di : ~o_data;
    o_wr_n = !w;
    o_rd_n = w;
    repeat (5) @(negedge i_clk);
    dq = i_bus;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    repeat (5) @(negedge i_clk);
    o_sel_n = 1'b1;
    o_data = ~o_data;
  endtask
endmodule // uhb_host

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dsr_n = 1'b1;
  logic ri_n = 1'b1;
  logic [7:0] dq, hd, rv;
  logic [2:0] ad;
  logic sel_n, rd_n, wr_n, oe, dtr_n, usr_n, irq, ioe, tx, rxv;
  uhb_pkg::uhb_src_t src = 3'h0;
  int fails = 0;
  int n_tests = 0;
  wire [7:0] bus = oe ? dq : hd;
  always #10 clk = ~clk;
  uhb_host u_host (.i_clk(clk), .i_bus(bus), .o_sel_n(sel_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(ad),
    .o_data(hd));
  uhb_channel u_dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_CHANNEL_SELECT_N(sel_n), .I_ADDR(ad),
    .I_READ_STROBE_N(rd_n), .I_WRITE_STROBE_N(wr_n), .I_DATA(bus), .O_DATA(dq), .O_DATA_OE(oe),
    .I_SET_READY_IN_N(dsr_n), .I_RING_IN_N(ri_n), .O_TERMINAL_READY_OUT_N(dtr_n), .O_USER_OUTPUT_N(usr_n),
    .O_CHANNEL_IRQ(irq), .O_CHANNEL_IRQ_OE(ioe), .I_SRC(src), .I_SERIAL_RX(1'b1), .O_SERIAL_TX(tx),
    .O_SERIAL_RX_VALID(rxv), .I_SERIAL_TX_IN(1'b0));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, rv);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    u_host.acc(1'b0, a, 8'h00, rv);
    chk(rv, e);
  endtask
  // 18 accesses of 11 cycles each fit well inside this
  initial
  begin
    #50000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(negedge clk);
    chk({tx, rxv, dtr_n, usr_n, ioe, oe}, 8'h2c);
    rst = 1'b0;
    wr(3'h4, 8'h01);
    chk({tx, rxv}, 8'h01);
    chk(dtr_n, 1'b0);
    rdc(3'h4, 8'h01);
    wr(3'h4, 8'h00);
    chk(dtr_n, 1'b1);
    wr(3'h7, 8'ha5);
    rdc(3'h7, 8'ha5);
    rdc(3'h2, 8'h00);
    wr(3'h4, 8'h08);
    chk({usr_n, ioe}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      src = {i == 2, i == 0, i == 1};
      wr(3'h1, 8'h00);
      chk(irq, 1'b0);
      wr(3'h1, 8'(8'h01 << i));
      chk(irq, 1'b1);
    end
    wr(3'h4, 8'h00);
    chk({irq, ioe, usr_n}, 8'h01);
    src = 3'h0;
    dsr_n = 1'b0;
    ri_n = 1'b0;
    repeat (4) @(negedge clk);
    ri_n = 1'b1;
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h08);
    chk(irq, 1'b1);
    rdc(3'h6, 8'h26);
    rdc(3'h6, 8'h20);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule // tb_top
